// ---- bench/pce_encoder_tb.sv ----
// Self-checking bench for the punctured convolutional encoder
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_count++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module pce_encoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// Signals
	logic          clk;
	logic          rstn;
	logic          start;
	logic          fast;
	logic [13:0]   len_pin;
	logic [8:0]    blk_pin [4];
	logic [4:0]    idx_pin [4];
	logic [7:0]    pad_pin;
	logic [3:0]    gap;
	logic [0:1023] fbits;
	logic          f_bit;
	logic          f_valid;
	logic          f_sof;
	logic          f_ready;
	logic          c_bit;
	logic          c_valid;
	logic          c_last;
	logic          busy;
	logic          exp_q [$];
	logic          got_q [$];
	int            got_last;
	int            cur_len;
	int            cl [4];
	int            cp [4];
	int            err_count;
	int            samples_checked;
	// ====================
	// Instances
	pce_source_model pce_source_model_inst (
		.i_clk(clk), .i_rstn(rstn), .i_start(start), .i_len(len_pin),
		.i_gap(gap), .i_bits(fbits), .i_ready(f_ready), .o_bit(f_bit),
		.o_valid(f_valid), .o_sof(f_sof));
	pce_encoder pce_encoder_inst (
		.I_CORE_CLK(clk), .I_RSTN(rstn), .I_FRAME_BIT(f_bit),
		.I_FRAME_VALID(f_valid), .I_FRAME_SOF(f_sof),
		.O_FRAME_READY(f_ready), .I_FAST_MODE(fast), .I_FRAME_LEN(len_pin),
		.I_BLOCKS_G1(blk_pin[0]), .I_BLOCKS_G2(blk_pin[1]),
		.I_BLOCKS_G3(blk_pin[2]), .I_BLOCKS_G4(blk_pin[3]),
		.I_INDEX_G1(idx_pin[0]), .I_INDEX_G2(idx_pin[1]),
		.I_INDEX_G3(idx_pin[2]), .I_INDEX_G4(idx_pin[3]),
		.I_PAD_BITS(pad_pin), .O_CODE_BIT(c_bit), .O_CODE_VALID(c_valid),
		.O_CODE_LAST(c_last), .O_BUSY(busy));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Output bits stand one cycle, so the falling edge sees each once
	always @(negedge clk) begin
		if (c_valid === 1'b1) begin
			got_q.push_back(c_bit);
			if (c_last === 1'b1) got_last = got_q.size();
		end
	end
	// ====================
	// Reference coder
	function automatic logic a(int j);
		return (j >= 0 && j < cur_len) ? fbits[j] : 1'b0;
	endfunction
	task automatic build_exp(input int pad);
		logic [3:0] x;
		int         n;
		int         g;
		exp_q = {};
		for (int i = 0; i < cur_len + 6; i++) begin
			x[0] = a(i) ^ a(i-2) ^ a(i-3) ^ a(i-5) ^ a(i-6);
			x[1] = a(i) ^ a(i-1) ^ a(i-2) ^ a(i-3) ^ a(i-6);
			x[2] = a(i) ^ a(i-1) ^ a(i-4) ^ a(i-6);
			x[3] = x[0];
			for (int b = 0; b < 4; b++) begin
				n = 4 * i + b;
				g = (n/128 < cl[0]) ? 0 : (n/128 < cl[0]+cl[1]) ? 1 :
				    (n/128 < cl[0]+cl[1]+cl[2]) ? 2 : 3;
				if (i >= cur_len ? b < 2 :
				    pce_pkg::PUNCT_VEC[cp[g]-1][31 - n % 32])
					exp_q.push_back(x[b]);
			end
		end
		repeat (pad) exp_q.push_back(1'b0);
	endtask
	// ====================
	// Shared steps
	task automatic set_cfg(input int ln, l0, l1, l2, l3, p0, p1, p2, p3, pd);
		len_pin = 14'(ln);
		cl = '{l0, l1, l2, l3};
		cp = '{p0, p1, p2, p3};
		foreach (cl[i]) blk_pin[i] = 9'(cl[i]);
		foreach (cp[i]) idx_pin[i] = 5'(cp[i]);
		pad_pin = 8'(pd);
	endtask
	task automatic run_frame(input int ln, input int pad);
		int t;
		cur_len = ln;
		build_exp(pad);
		got_q = {};
		got_last = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		t = 0;
		while (got_last == 0 && t < 20000) begin
			@(negedge clk);
			t++;
		end
		`CHK(got_q.size(), exp_q.size())
		`CHK(got_last, exp_q.size())
		foreach (exp_q[i])
			if (i < got_q.size()) `CHK(got_q[i], exp_q[i])
		repeat (2) @(negedge clk);
		`CHK(busy, 1'b0)
		`CHK(f_ready, 1'b1)
	endtask
	// ====================
	// Scenarios
	task automatic t_reset();
		`CHK(busy, 1'b0)
		`CHK(f_ready, 1'b0)
		`CHK(c_valid, 1'b0)
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(f_ready, 1'b1)
	endtask
	task automatic t_all_index();
		for (int k = 1; k <= 24; k++) begin
			`CHK($countones(pce_pkg::PUNCT_VEC[k-1]), 8 + k)
			for (int j = 0; j < 32; j++)
				fbits[j] = ((j * 7 + k) % 3 == 0) ^ (j % 5 == 1);
			set_cfg(32, 1, 0, 0, 0, k, 24, 24, 24, 0);
			run_frame(32, 0);
		end
		// An index past the table keeps every bit
		set_cfg(32, 1, 0, 0, 0, 25, 24, 24, 24, 0);
		cp[0] = 24;
		run_frame(32, 0);
	endtask
	task automatic t_fast();
		fast = 1'b1;
		for (int j = 0; j < 768; j++) fbits[j] = (j % 9 < 4) ^ (j % 13 == 0);
		// Profile pins hold other values; fast mode must ignore them
		set_cfg(768, 24, 0, 0, 0, 24, 24, 24, 24, 8);
		cl = '{21, 3, 0, 0};
		cp = '{16, 15, 15, 15};
		run_frame(768, 0);
		`CHK(exp_q.size(), 2304)
		fast = 1'b0;
	endtask
	task automatic t_unequal();
		gap = 4'h6;
		for (int j = 0; j < 768; j++) fbits[j] = (j % 11 < 5);
		set_cfg(768, 3, 5, 13, 3, 24, 17, 12, 17, 4);
		run_frame(768, 4);
		`CHK(exp_q.size() % 64, 0)
		gap = 4'h0;
	endtask
	task automatic t_abort();
		set_cfg(768, 24, 0, 0, 0, 5, 5, 5, 5, 0);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (200) @(negedge clk);
		`CHK(busy, 1'b1)
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(busy, 1'b0)
		`CHK(c_valid, 1'b0)
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		fbits[0:31] = '1;
		set_cfg(32, 1, 0, 0, 0, 24, 24, 24, 24, 0);
		run_frame(32, 0);
	endtask
	// ====================
	// Run control
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		fast = 1'b0;
		gap = 4'h0;
		fbits = '0;
		err_count = 0;
		samples_checked = 0;
		set_cfg(32, 1, 0, 0, 0, 1, 1, 1, 1, 0);
		repeat (16) @(posedge clk);
		@(negedge clk);
		t_reset();
		t_all_index();
		t_fast();
		t_unequal();
		t_abort();
		report_and_stop();
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
endmodule // pce_encoder_tb

// ---- bench/pce_source_model.sv ----
// Upstream scrambler model: offers frame bits by valid/ready
module pce_source_model (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rstn,
	// Frame request from the bench
	input  wire logic          i_start,
	input  wire logic [13:0]   i_len,
	input  wire logic [3:0]    i_gap,
	input  wire logic [0:1023] i_bits,
	// Handshake toward the encoder
	input  wire logic          i_ready,
	output logic               o_bit,
	output logic               o_valid,
	output logic               o_sof
);
	timeunit 1ns;
	timeprecision 1ps;
	logic go_ff;
	logic taken_ff;
	int   pos;
	int   hold;
	initial begin
		o_bit = 1'b0;
		o_valid = 1'b0;
		o_sof = 1'b0;
		pos = 0;
		hold = 0;
	end
	always @(posedge i_clk) begin
		go_ff    <= i_start & i_rstn;
		taken_ff <= o_valid & i_ready;
	end
	// Request changes on the falling edge, held until taken; idle bit toggles
	always @(negedge i_clk) begin
		if (!i_rstn) begin
			o_valid <= 1'b0;
			o_sof   <= 1'b0;
			hold = 0;
		end else if (go_ff) begin
			pos = 0;
			hold = 0;
			o_valid <= 1'b1;
			o_sof   <= 1'b1;
			o_bit   <= i_bits[0];
		end else if (taken_ff) begin
			pos++;
			hold = i_gap;
			o_sof   <= 1'b0;
			o_valid <= (pos < i_len) && (hold == 0);
			o_bit   <= (pos < i_len && hold == 0) ? i_bits[pos] : ~o_bit;
		end else if (hold > 0) begin
			hold--;
			o_valid <= (hold == 0) && (pos < i_len);
			o_bit   <= (hold == 0 && pos < i_len) ? i_bits[pos] : ~o_bit;
		end else if (!o_valid) begin
			o_bit <= ~o_bit;
		end
	end
endmodule // pce_source_model

// ---- src/pce_encoder.sv ----
// Punctured convolutional channel encoder, bit-serial
// ==========================================================
// What this block does
// [RULE1] Each incoming frame is coded on its own, from a fresh start.
// [RULE2] Constraint length 7 mother code, six memory stages, four bits per input.
// [RULE3] Branch generators are octal 133, 171, 145, 133 as parity sums.
// [RULE4] The shift register is all zero before the first bit of a frame.
// [RULE5] Six zero steps follow the frame bits, returning the register to zero.
// [RULE6] Each step sends branches zero to three in order.
// [RULE7] Frame-bit part of the codeword is cut into 128-bit blocks.
// [RULE8] Each block is four 32-bit sub-blocks sharing one puncture index.
// [RULE9] Sub-block bit k is dropped when vector element k is zero.
// [RULE10] Index 1..24 keeps 8 plus index bits per sub-block.
// [RULE11] The 24 fixed puncture vectors are held as constants.
// [RULE12] The 24 tail bits are punctured by 1100 repeated, keeping 12.
// [RULE13] Blocks go out in order, then the 12 tail bits.
// [RULE14] Zero padding bits follow the codeword when configured.
// [RULE15] Fast channel mode: 768 bits, 21 blocks index 16, 3 blocks index 15.
// [RULE16] Four block groups with their own counts and indices form a profile.
// [RULE17] Input by valid/ready with start marker; output valid and last.
// [RULE18] Configuration is stable and supplied before each frame starts.
module pce_encoder #(
	parameter int LEN_W = 14,
	parameter int BLK_W = 9,
	parameter int PAD_W = 8
) (
	// Clock and reset
	input  wire logic             I_CORE_CLK,
	input  wire logic             I_RSTN,
	// Frame bits from the scrambler
	input  wire logic             I_FRAME_BIT,
	input  wire logic             I_FRAME_VALID,
	input  wire logic             I_FRAME_SOF,
	output logic                  O_FRAME_READY,
	// Protection profile, sampled with the start marker
	input  wire logic             I_FAST_MODE,
	input  wire logic [LEN_W-1:0] I_FRAME_LEN,
	input  wire logic [BLK_W-1:0] I_BLOCKS_G1,
	input  wire logic [BLK_W-1:0] I_BLOCKS_G2,
	input  wire logic [BLK_W-1:0] I_BLOCKS_G3,
	input  wire logic [BLK_W-1:0] I_BLOCKS_G4,
	input  wire logic [4:0]       I_INDEX_G1,
	input  wire logic [4:0]       I_INDEX_G2,
	input  wire logic [4:0]       I_INDEX_G3,
	input  wire logic [4:0]       I_INDEX_G4,
	input  wire logic [PAD_W-1:0] I_PAD_BITS,
	// Coded bits to the interleaver
	output logic                  O_CODE_BIT,
	output logic                  O_CODE_VALID,
	output logic                  O_CODE_LAST,
	output logic                  O_BUSY
);

	// ==========================================================
	// Declarations
	// ==========================================================
	pce_pkg::pce_state_e state_ff;
	pce_pkg::pce_state_e nxt_state;
	logic [1:0]       phase_ff;
	logic [1:0]       nxt_phase;
	logic [5:0]       sr_ff;
	logic             cur_bit_ff;
	logic [LEN_W-1:0] bit_cnt_ff;
	logic [LEN_W-1:0] len_ff;
	logic [BLK_W-1:0] blocks_ff [4];
	logic [4:0]       index_ff [4];
	logic [PAD_W-1:0] pad_ff;
	logic [PAD_W-1:0] pad_cnt_ff;
	logic [1:0]       grp_ff;
	logic [BLK_W-1:0] blk_in_grp_ff;
	logic [6:0]       pos_ff;
	logic [2:0]       tail_step_ff;
	logic             ready_ff;
	logic             code_bit_ff;
	logic             code_valid_ff;
	logic             code_last_ff;
	logic             busy_ff;
	logic [BLK_W-1:0] cfg_blocks [4];
	logic [4:0]       cfg_index [4];
	logic [3:0]       cfg_nz;
	logic [3:0]       run_nz;
	logic             accept;
	logic             go;
	logic             bit_now;
	logic [6:0]       win;
	logic             branch_bit;
	logic [4:0]       cur_index;
	logic [31:0]      cur_vec;
	logic             keep;
	logic             blk_end;
	logic             tail_end;

	// First group at or after 'from' that holds blocks; the last otherwise
	function automatic logic [1:0] pick_grp(input logic [3:0] nz,
		input logic [2:0] from);
		logic [1:0] g;
		g = 2'h3;
		for (int j = 3; j >= 0; j--) begin
			if (nz[j] && (3'(j) >= from)) begin
				g = 2'(j);
			end
		end
		return g;
	endfunction

	// ==========================================================
	// Configuration select
	// ==========================================================
	always_comb begin
		if (I_FAST_MODE) begin // RULE15
			cfg_blocks = '{BLK_W'(pce_pkg::FAST_BLOCKS1),
				BLK_W'(pce_pkg::FAST_BLOCKS2), '0, '0};
			cfg_index  = '{pce_pkg::FAST_INDEX1, pce_pkg::FAST_INDEX2,
				pce_pkg::INDEX_MAX, pce_pkg::INDEX_MAX};
		end else begin // RULE16
			cfg_blocks = '{I_BLOCKS_G1, I_BLOCKS_G2, I_BLOCKS_G3, I_BLOCKS_G4};
			cfg_index  = '{I_INDEX_G1, I_INDEX_G2, I_INDEX_G3, I_INDEX_G4};
		end
		for (int j = 0; j < 4; j++) begin
			cfg_nz[j] = (cfg_blocks[j] != '0);
			run_nz[j] = (blocks_ff[j] != '0);
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			len_ff <= '0;
			pad_ff <= '0;
			for (int j = 0; j < 4; j++) begin
				blocks_ff[j] <= '0;
				index_ff[j]  <= pce_pkg::INDEX_MAX;
			end
		end else if (state_ff == pce_pkg::ST_IDLE && accept) begin // RULE18
			len_ff    <= I_FAST_MODE ? LEN_W'(pce_pkg::FAST_LEN) : I_FRAME_LEN;
			pad_ff    <= I_FAST_MODE ? '0 : I_PAD_BITS;
			blocks_ff <= cfg_blocks;
			index_ff  <= cfg_index;
		end
	end

	// ==========================================================
	// Step control
	// ==========================================================
	// A bit without the start marker is taken and dropped while idle
	assign accept = ready_ff && I_FRAME_VALID &&
		(state_ff != pce_pkg::ST_IDLE || I_FRAME_SOF); // RULE17
	assign go = (state_ff == pce_pkg::ST_IDLE && accept) ||
		(state_ff == pce_pkg::ST_DATA && (phase_ff != 2'h0 || accept)) ||
		(state_ff == pce_pkg::ST_TAIL);
	assign tail_end = state_ff == pce_pkg::ST_TAIL && phase_ff == 2'h3 &&
		tail_step_ff == pce_pkg::TAIL_STEPS - 3'h1;

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = go ? phase_ff + 2'h1 : phase_ff;
		unique case (state_ff)
			pce_pkg::ST_IDLE: if (accept) nxt_state = pce_pkg::ST_DATA;
			pce_pkg::ST_DATA: begin
				if (phase_ff == 2'h3 && bit_cnt_ff == len_ff) begin // RULE5
					nxt_state = pce_pkg::ST_TAIL;
				end
			end
			pce_pkg::ST_TAIL: begin
				if (tail_end) begin // RULE14
					nxt_state = (pad_ff != '0) ? pce_pkg::ST_PAD :
						pce_pkg::ST_IDLE;
				end
			end
			pce_pkg::ST_PAD: begin
				if (pad_cnt_ff == PAD_W'(1)) nxt_state = pce_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			state_ff <= pce_pkg::ST_IDLE;
			phase_ff <= 2'h0;
			ready_ff <= 1'b0;
			busy_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			ready_ff <= nxt_state == pce_pkg::ST_IDLE ||
				(nxt_state == pce_pkg::ST_DATA && nxt_phase == 2'h0);
			busy_ff  <= nxt_state != pce_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			bit_cnt_ff   <= '0;
			tail_step_ff <= 3'h0;
			pad_cnt_ff   <= '0;
		end else begin
			if (state_ff == pce_pkg::ST_IDLE) begin
				bit_cnt_ff <= LEN_W'(accept);
			end else if (accept) begin
				bit_cnt_ff <= bit_cnt_ff + LEN_W'(1);
			end
			if (state_ff != pce_pkg::ST_TAIL) begin
				tail_step_ff <= 3'h0;
			end else if (phase_ff == 2'h3) begin
				tail_step_ff <= tail_step_ff + 3'h1;
			end
			if (state_ff == pce_pkg::ST_PAD) begin
				pad_cnt_ff <= pad_cnt_ff - PAD_W'(1);
			end else begin
				pad_cnt_ff <= pad_ff;
			end
		end
	end

	// ==========================================================
	// Mother encoder
	// ==========================================================
	assign bit_now = (state_ff == pce_pkg::ST_TAIL) ? 1'b0 : // RULE5
		(phase_ff == 2'h0 ? I_FRAME_BIT : cur_bit_ff);
	assign win        = {bit_now, sr_ff};
	assign branch_bit = ^(win & pce_pkg::GEN_POLY[phase_ff]); // RULE3 RULE6

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			sr_ff      <= 6'h00;
			cur_bit_ff <= 1'b0;
		end else begin
			if (accept) cur_bit_ff <= I_FRAME_BIT;
			if (state_ff == pce_pkg::ST_IDLE) begin
				sr_ff <= 6'h00; // RULE4 RULE1
			end else if (go && phase_ff == 2'h3) begin
				sr_ff <= {bit_now, sr_ff[5:1]}; // RULE2
			end
		end
	end

	// ==========================================================
	// Puncturing
	// ==========================================================
	// Out-of-range indices are treated as keep-all
	assign cur_index = (index_ff[grp_ff] < pce_pkg::INDEX_MIN ||
		index_ff[grp_ff] > pce_pkg::INDEX_MAX) ? pce_pkg::INDEX_MAX :
		index_ff[grp_ff];
	assign cur_vec = pce_pkg::PUNCT_VEC[cur_index - 5'h01]; // RULE11 RULE10
	assign blk_end = state_ff == pce_pkg::ST_DATA && go && pos_ff == 7'h7F;

	always_comb begin
		unique case (state_ff)
			// Element 0 of every vector is one
			pce_pkg::ST_IDLE: keep = 1'b1;
			pce_pkg::ST_DATA: keep = cur_vec[5'h1F - pos_ff[4:0]]; // RULE9
			pce_pkg::ST_TAIL: keep = phase_ff < pce_pkg::TAIL_KEEP_PHASES; // RULE12
			pce_pkg::ST_PAD:  keep = 1'b1;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			pos_ff        <= 7'h00;
			grp_ff        <= 2'h0;
			blk_in_grp_ff <= '0;
		end else if (state_ff == pce_pkg::ST_IDLE) begin
			pos_ff        <= {6'h00, accept};
			grp_ff        <= pick_grp(cfg_nz, 3'h0);
			blk_in_grp_ff <= '0;
		end else if (go && state_ff == pce_pkg::ST_DATA) begin
			pos_ff <= pos_ff + 7'h01; // RULE7 RULE8
			if (blk_end) begin
				if (blk_in_grp_ff + BLK_W'(1) >= blocks_ff[grp_ff]) begin
					grp_ff        <= pick_grp(run_nz, 3'(grp_ff) + 3'h1); // RULE16
					blk_in_grp_ff <= '0;
				end else begin
					blk_in_grp_ff <= blk_in_grp_ff + BLK_W'(1);
				end
			end
		end
	end

	// ==========================================================
	// Output
	// ==========================================================
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN) begin
			code_bit_ff   <= 1'b0;
			code_valid_ff <= 1'b0;
			code_last_ff  <= 1'b0;
		end else begin
			code_valid_ff <= (go && keep) || state_ff == pce_pkg::ST_PAD; // RULE13
			code_bit_ff   <= (state_ff == pce_pkg::ST_PAD) ? 1'b0 : branch_bit; // RULE14
			code_last_ff  <= (state_ff == pce_pkg::ST_PAD &&
				pad_cnt_ff == PAD_W'(1)) || (state_ff == pce_pkg::ST_TAIL &&
				pad_ff == '0 && phase_ff == 2'h1 &&
				tail_step_ff == pce_pkg::TAIL_STEPS - 3'h1); // RULE17
		end
	end

	assign O_FRAME_READY = ready_ff;
	assign O_CODE_BIT    = code_bit_ff;
	assign O_CODE_VALID  = code_valid_ff;
	assign O_CODE_LAST   = code_last_ff;
	assign O_BUSY        = busy_ff;

	// ==========================================================
	// Assertions
	// ==========================================================
	logic [7:0] kept_cnt_ff;

	// The first bit is taken while idle and belongs to block zero
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RSTN || blk_end) begin
			kept_cnt_ff <= 8'h00;
		end else if (state_ff == pce_pkg::ST_IDLE) begin
			kept_cnt_ff <= {7'h00, accept};
		end else if (state_ff == pce_pkg::ST_DATA && go && keep) begin
			kept_cnt_ff <= kept_cnt_ff + 8'h01;
		end
	end

	property p_block_keep;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		blk_end |-> (kept_cnt_ff + 8'(keep)) == 8'(4 * (8 + int'(cur_index)));
	endproperty
	a_block_keep: assert property (p_block_keep) else $error("block keep count wrong"); // RULE10

	property p_first_bit;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		(state_ff == pce_pkg::ST_IDLE && accept) |=>
			O_CODE_VALID && O_CODE_BIT == $past(I_FRAME_BIT);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first branch bit wrong"); // RULE3

	property p_idle_clear;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		state_ff == pce_pkg::ST_IDLE |-> sr_ff == 6'h00;
	endproperty
	a_idle_clear: assert property (p_idle_clear) else $error("register not zero at start"); // RULE4

	property p_tail_zero;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		tail_end |=> sr_ff == 6'h00 && state_ff != pce_pkg::ST_TAIL;
	endproperty
	a_tail_zero: assert property (p_tail_zero) else $error("tail did not flush"); // RULE5

	property p_four_phases;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		(state_ff == pce_pkg::ST_DATA && accept) |=>
			phase_ff == 2'h1 ##1 phase_ff == 2'h2 ##1 phase_ff == 2'h3;
	endproperty
	a_four_phases: assert property (p_four_phases) else $error("branch order broken"); // RULE6

	property p_tail_keep;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		state_ff == pce_pkg::ST_TAIL |=> O_CODE_VALID == ($past(phase_ff) < 2'h2);
	endproperty
	a_tail_keep: assert property (p_tail_keep) else $error("tail puncture wrong"); // RULE12

	property p_pad_zero;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		state_ff == pce_pkg::ST_PAD |=> O_CODE_VALID && !O_CODE_BIT;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("padding bit not zero"); // RULE14

	property p_stall;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		(state_ff == pce_pkg::ST_DATA && phase_ff == 2'h0 && !I_FRAME_VALID)
			|=> !O_CODE_VALID && O_FRAME_READY;
	endproperty
	a_stall: assert property (p_stall) else $error("output without input"); // RULE17

	property p_fast_cfg;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		(state_ff == pce_pkg::ST_IDLE && accept && I_FAST_MODE) |=>
			len_ff == pce_pkg::FAST_LEN && pad_ff == '0 && grp_ff == 2'h0;
	endproperty
	a_fast_cfg: assert property (p_fast_cfg) else $error("fast channel profile wrong"); // RULE15

	property p_last_end;
		@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		O_CODE_LAST |-> O_CODE_VALID ##1 !O_CODE_LAST;
	endproperty
	a_last_end: assert property (p_last_end) else $error("last marker misplaced"); // RULE13

	c_fast_frame: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		len_ff == pce_pkg::FAST_LEN && O_CODE_LAST);
	c_padded: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		state_ff == pce_pkg::ST_PAD ##1 O_CODE_LAST);
	c_group_step: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		blk_end ##1 grp_ff == 2'h1);
	c_stall: cover property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		state_ff == pce_pkg::ST_DATA && O_FRAME_READY && !I_FRAME_VALID);

endmodule // pce_encoder

// ---- src/pce_pkg.sv ----
// Constants shared by the punctured convolutional encoder
package pce_pkg;

	// ==========================================================
	// Mother code
	// ==========================================================
	localparam int          MEM_STAGES = 6;
	localparam int          BRANCHES   = 4;
	// Taps over {a_i, a_i-1, ..., a_i-6}, octal 133, 171, 145, 133
	localparam logic [6:0]  GEN_POLY [BRANCHES] = '{7'h5B, 7'h79, 7'h65, 7'h5B};

	// ==========================================================
	// Puncturing
	// ==========================================================
	localparam int          BLOCK_BITS = 128;
	localparam int          SUB_BITS   = 32;
	localparam logic [4:0]  INDEX_MIN  = 5'h01;
	localparam logic [4:0]  INDEX_MAX  = 5'h18;
	// Element 0 of each vector sits in bit 31
	localparam logic [31:0] PUNCT_VEC [24] = '{
		32'hC8888888, 32'hC888C888, 32'hC8C8C888, 32'hC8C8C8C8,
		32'hCCC8C8C8, 32'hCCC8CCC8, 32'hCCCCCCC8, 32'hCCCCCCCC,
		32'hECCCCCCC, 32'hECCCECCC, 32'hECECECCC, 32'hECECECEC,
		32'hEEECECEC, 32'hEEECEEEC, 32'hEEEEEEEC, 32'hEEEEEEEE,
		32'hFEEEEEEE, 32'hFEEEFEEE, 32'hFEFEFEEE, 32'hFEFEFEFE,
		32'hFFFEFEFE, 32'hFFFEFFFE, 32'hFFFFFFFE, 32'hFFFFFFFF};
	// Tail vector 1100 repeated six times: keep phases 0 and 1
	localparam logic [1:0]  TAIL_KEEP_PHASES = 2'h2;
	localparam logic [2:0]  TAIL_STEPS       = 3'h6;

	// ==========================================================
	// Fast information channel, mode one
	// ==========================================================
	localparam logic [13:0] FAST_LEN     = 14'h0300;
	localparam logic [8:0]  FAST_BLOCKS1 = 9'h015;
	localparam logic [8:0]  FAST_BLOCKS2 = 9'h003;
	localparam logic [4:0]  FAST_INDEX1  = 5'h10;
	localparam logic [4:0]  FAST_INDEX2  = 5'h0F;

	// ==========================================================
	// Frame sequencer
	// ==========================================================
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DATA = 2'h1,
		ST_TAIL = 2'h3,
		ST_PAD  = 2'h2
	} pce_state_e;

endpackage
